// ---- common/dop_pkg.sv ----
// Types shared by the directional phase overcurrent block.
// Assumes nothing beyond a SystemVerilog compiler.
package dop_pkg;

	// ======================================================================
	// Operating modes of a stage
	typedef enum logic [1:0]
	{
		dop_dir,
		dop_nondir,
		dop_dirback
	} dop_mode_t;

	typedef logic signed [8:0] dop_angle_t;

endpackage : dop_pkg

// ---- common/dop_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
//
// Function
// - Overcurrent when the largest phase current exceeds the stage threshold.
// - Start when overcurrent and direction hold; trip once delay has run.
// - Non-earth faults: direction from positive-sequence current and voltage.
// - Reference is rotated positive-sequence voltage; sector is plus/minus 88.
// - Positive-sequence current magnitude affects neither decision.
// - Earth faults: faulted phase current against healthy line voltage.
// - Earth reference: inverted line voltage, base angle plus 90; sector 88.
// - Cyclic voltage memory adjustable from 0.2 to 3.2 seconds.
// - All line voltages below one percent: use stored angle as reference.
// - Non-directional mode ignores direction; plain overcurrent stage.
// - Backup mode goes non-directional once voltages vanish, memory expired.
// - Only fundamental phase current magnitudes form the overcurrent test.
// - Four independent stages: two low-set and two high-set.
// - Low-set stages definite or dependent time; high-set definite only.
// - Each stage holds four selectable setting groups.
`ifndef DOP_REGS_SVH
`define DOP_REGS_SVH

// ==========================================================================
// Register offsets
`define DOP_CTRL_OFF      12'h000
`define DOP_STATUS_OFF    12'h004
`define DOP_IRQ_STAT_OFF  12'h008
`define DOP_IRQ_EN_OFF    12'h00C
`define DOP_IRQ_CLR_OFF   12'h010
`define DOP_SET_BASE      12'h100
`define DOP_SET_MASK      12'hF00

// ==========================================================================
// Setting word selectors inside a stage/group block of 16 bytes
`define DOP_SET_THR       2'h0
`define DOP_SET_DLY       2'h1
`define DOP_SET_BASEANG   2'h2
`define DOP_SET_MODE      2'h3

// ==========================================================================
// Control fields and reset values
`define DOP_CTRL_GRP_LSB  0
`define DOP_CTRL_EVT_BIT  4
`define DOP_CTRL_MEM_LSB  8
`define DOP_MODE_DEP_BIT  2
`define DOP_MEM_LEN_RST   6'h0A
`define DOP_MEM_LEN_MIN   6'h02
`define DOP_MEM_LEN_MAX   6'h20
`define DOP_THR_RST       16'hFFFF
`define DOP_DLY_RST       16'h0064

// ==========================================================================
// Angles in degrees, voltages in percent
`define DOP_SECTOR_DEG    88
`define DOP_EARTH_ROT_DEG 90
`define DOP_INVERT_DEG    180
`define DOP_FULL_DEG      360
`define DOP_VMIN_PCT      1
`define DOP_PCT_FULL      100

// ==========================================================================
// Timing
`define DOP_CLK_PS        4000
`define DOP_TICK_PS       1000000000
`define DOP_SLOT_MS       100

`endif

// ---- hdl/dop_stage_top.sv ----
// Four-stage directional phase overcurrent protection with APB registers.
// Assumes measurement inputs on pclk, refreshed by the front end.
`timescale 1ns/1ns
`include "dop_regs.svh"

module dop_stage_top #(
	parameter int unsigned         TICK_CYC = `DOP_TICK_PS / `DOP_CLK_PS,
	parameter logic        [15:0]  VNOM     = 16'h4000,
	parameter int unsigned         NSTG     = 4,
	parameter int unsigned         MEM_DEP  = 32
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic        [11:0]   paddr,
	input  wire logic        [31:0]   pwdata,
	output logic             [31:0]   prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Fundamental phase current magnitudes
	input  wire logic        [15:0]   i_l1_mag,
	input  wire logic        [15:0]   i_l2_mag,
	input  wire logic        [15:0]   i_l3_mag,
	// Line-to-line voltage magnitudes
	input  wire logic        [15:0]   u_l12_mag,
	input  wire logic        [15:0]   u_l23_mag,
	input  wire logic        [15:0]   u_l31_mag,
	// Phase angles in degrees, -180 to 179
	input  wire dop_pkg::dop_angle_t  pos_seq_cur_ang,
	input  wire dop_pkg::dop_angle_t  pos_seq_volt_ang,
	input  wire dop_pkg::dop_angle_t  flt_cur_ang,
	input  wire dop_pkg::dop_angle_t  healthy_ll_ang,
	input  wire logic                 earth_fault,
	// Stage block inputs
	input  wire logic        [3:0]    block_in,
	// Protection outputs
	output logic             [3:0]    start_out,
	output logic             [3:0]    trip_out,
	output logic                      irq
);

	// ======================================================================
	// Functions
	function automatic dop_pkg::dop_angle_t wrap_ang(input logic signed [11:0] a);
		logic signed [11:0] w;
		w = a;
		for (int k = 0; k < 3; k++)
		begin
			if (w > 12'sd179)
				w = w - 12'sd`DOP_FULL_DEG;
			else if (w < -12'sd180)
				w = w + 12'sd`DOP_FULL_DEG;
		end
		return w[8:0];
	endfunction : wrap_ang

	function automatic logic in_sector(input dop_pkg::dop_angle_t d);
		return (d >= -9'sd`DOP_SECTOR_DEG) && (d <= 9'sd`DOP_SECTOR_DEG);
	endfunction : in_sector

	function automatic logic is_low(input logic [15:0] u);
		logic [23:0] lhs;
		logic [23:0] rhs;
		lhs = u * 8'd`DOP_PCT_FULL;
		rhs = VNOM * 8'd`DOP_VMIN_PCT;
		return lhs < rhs;
	endfunction : is_low

	// ======================================================================
	// Registers
	logic        [1:0]   grp_ff;
	logic                evt_en_ff;
	logic        [5:0]   mem_len_ff;
	logic        [7:0]   irq_stat_ff;
	logic        [7:0]   irq_en_ff;
	logic        [31:0]  prdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	logic        [3:0]   start_ff;
	logic        [3:0]   trip_ff;
	logic                irq_ff;
	logic        [15:0]  thr_ff  [16];
	logic        [15:0]  dly_ff  [16];
	logic signed [8:0]   base_ff [16];
	logic        [2:0]   mode_ff [16];
	logic        [17:0]  vmem    [MEM_DEP];
	logic        [4:0]   wr_ptr_ff;
	logic        [17:0]  tick_ff;
	logic        [6:0]   slot_ff;
	logic        [5:0]   age_ff;
	logic                coll_ff;
	logic        [17:0]  held_ff;
	logic        [31:0]  acc_ff  [4];

	// ======================================================================
	// APB decode
	wire         acc_ph   = psel & penable & ~pready_ff;
	wire         wr_en    = psel & penable & pready_ff & pwrite;
	wire         hit_ctrl = paddr == `DOP_CTRL_OFF;
	wire         hit_stat = paddr == `DOP_STATUS_OFF;
	wire         hit_ist  = paddr == `DOP_IRQ_STAT_OFF;
	wire         hit_ien  = paddr == `DOP_IRQ_EN_OFF;
	wire         hit_iclr = paddr == `DOP_IRQ_CLR_OFF;
	wire         hit_set  = (paddr & `DOP_SET_MASK) == `DOP_SET_BASE;
	wire         mapped   = hit_ctrl | hit_stat | hit_ist | hit_ien
	                      | hit_iclr | hit_set;
	wire [3:0]   set_idx  = paddr[7:4];
	wire [1:0]   set_fld  = paddr[3:2];
	wire         set_wr   = wr_en & hit_set;
	wire [5:0]   len_req  = pwdata[`DOP_CTRL_MEM_LSB +: 6];
	wire [5:0]   len_clip = (len_req < `DOP_MEM_LEN_MIN) ? `DOP_MEM_LEN_MIN :
	                        (len_req > `DOP_MEM_LEN_MAX) ? `DOP_MEM_LEN_MAX :
	                        len_req;
	wire [31:0]  rd_ctrl  = {18'h00000, mem_len_ff, 3'h0, evt_en_ff,
	                         2'h0, grp_ff};
	wire [31:0]  rd_stat  = {20'h00000, 1'b0, age_ff < mem_len_ff, coll_ff,
	                         1'b0, trip_ff, start_ff};
	wire [31:0]  rd_set   = (set_fld == `DOP_SET_THR) ? {16'h0000, thr_ff[set_idx]} :
	                        (set_fld == `DOP_SET_DLY) ? {16'h0000, dly_ff[set_idx]} :
	                        (set_fld == `DOP_SET_BASEANG) ?
	                        {{23{base_ff[set_idx][8]}}, base_ff[set_idx]} :
	                        {29'h00000000, mode_ff[set_idx]};
	wire [31:0]  nxt_rdata = hit_ctrl ? rd_ctrl :
	                         hit_stat ? rd_stat :
	                         hit_ist  ? {24'h000000, irq_stat_ff} :
	                         hit_ien  ? {24'h000000, irq_en_ff} :
	                         hit_set  ? rd_set : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end
		else
		begin
			pready_ff  <= acc_ph;
			pslverr_ff <= acc_ph & ~mapped;
			prdata_ff  <= (acc_ph & ~pwrite) ? nxt_rdata : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			grp_ff     <= 2'h0;
			evt_en_ff  <= 1'b0;
			mem_len_ff <= `DOP_MEM_LEN_RST;
			irq_en_ff  <= 8'h00;
		end
		else if (wr_en & hit_ctrl)
		begin
			grp_ff     <= pwdata[`DOP_CTRL_GRP_LSB +: 2];
			evt_en_ff  <= pwdata[`DOP_CTRL_EVT_BIT];
			mem_len_ff <= len_clip;
		end
		else if (wr_en & hit_ien)
			irq_en_ff  <= pwdata[7:0];
	end

	// Setting groups per stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int k = 0; k < 16; k++)
			begin
				thr_ff[k]  <= `DOP_THR_RST;
				dly_ff[k]  <= `DOP_DLY_RST;
				base_ff[k] <= 9'sh000;
				mode_ff[k] <= 3'h0;
			end
		end
		else if (set_wr)
		begin
			unique case (set_fld)
				`DOP_SET_THR:     thr_ff[set_idx]  <= pwdata[15:0];
				`DOP_SET_DLY:     dly_ff[set_idx]  <= pwdata[15:0];
				`DOP_SET_BASEANG: base_ff[set_idx] <= pwdata[8:0];
				`DOP_SET_MODE:    mode_ff[set_idx] <= pwdata[2:0];
			endcase
		end
	end

	// ======================================================================
	// Largest fundamental phase current
	wire [15:0]  i_max12 = (i_l1_mag > i_l2_mag) ? i_l1_mag : i_l2_mag;
	wire [15:0]  i_max   = (i_max12 > i_l3_mag) ? i_max12 : i_l3_mag;

	// ======================================================================
	// Millisecond tick and voltage memory slots
	wire         tick     = tick_ff == 18'(TICK_CYC - 1);
	wire         slot_end = tick & (slot_ff == 7'(`DOP_SLOT_MS - 1));
	wire         collapse = is_low(u_l12_mag) & is_low(u_l23_mag)
	                      & is_low(u_l31_mag);
	wire [4:0]   rd_ptr   = wr_ptr_ff - mem_len_ff[4:0];
	wire         mem_ok   = age_ff < mem_len_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_ff <= 18'h00000;
			slot_ff <= 7'h00;
		end
		else
		begin
			tick_ff <= tick ? 18'h00000 : tick_ff + 18'h00001;
			if (tick)
				slot_ff <= slot_end ? 7'h00 : slot_ff + 7'h01;
		end
	end

	always_ff @(posedge pclk)
	begin
		if (slot_end & ~collapse)
			vmem[wr_ptr_ff] <= {pos_seq_volt_ang, healthy_ll_ang};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_ptr_ff <= 5'h00;
			age_ff    <= 6'h00;
			coll_ff   <= 1'b0;
			held_ff   <= 18'h00000;
		end
		else
		begin
			coll_ff <= collapse;
			if (collapse & ~coll_ff)
				held_ff <= vmem[rd_ptr];
			if (~collapse)
				age_ff <= 6'h00;
			else if (slot_end & mem_ok)
				age_ff <= age_ff + 6'h01;
			if (slot_end & ~collapse)
				wr_ptr_ff <= wr_ptr_ff + 5'h01;
		end
	end

	// ======================================================================
	// Reference angles
	wire dop_pkg::dop_angle_t  ref_pos = coll_ff ? held_ff[17:9]
	                                             : pos_seq_volt_ang;
	wire dop_pkg::dop_angle_t  ref_ll  = coll_ff ? held_ff[8:0]
	                                             : healthy_ll_ang;

	// ======================================================================
	// Stages
	logic [3:0]  cond;
	logic [3:0]  trip_hit;

	for (genvar s = 0; s < NSTG; s++)
	begin : g_stage
		wire [3:0]                 idx   = {2'(s), grp_ff};
		wire [15:0]                thr   = thr_ff[idx];
		wire dop_pkg::dop_mode_t   mode  = dop_pkg::dop_mode_t'(mode_ff[idx][1:0]);
		wire                       dep   = (s < 2) &
		                                   mode_ff[idx][`DOP_MODE_DEP_BIT];
		wire signed [11:0]         base  = 12'(base_ff[idx]);
		wire dop_pkg::dop_angle_t  d_pos = wrap_ang(12'(pos_seq_cur_ang)
		                                 - 12'(ref_pos) - base);
		wire dop_pkg::dop_angle_t  d_e   = wrap_ang(12'(flt_cur_ang)
		                                 - 12'(ref_ll)
		                                 - 12'sd`DOP_INVERT_DEG - base
		                                 - 12'sd`DOP_EARTH_ROT_DEG);
		wire                       ang_ok = earth_fault ? in_sector(d_e)
		                                                : in_sector(d_pos);
		wire                       dir_ok = ang_ok & (~coll_ff | mem_ok);
		wire                       oc    = i_max > thr;
		wire [31:0]                limit = dly_ff[idx] * thr;
		logic                      dcond;

		always_comb
		begin
			unique case (mode)
				dop_pkg::dop_nondir:  dcond = 1'b1;
				dop_pkg::dop_dirback: dcond = dir_ok
				                            | (coll_ff & ~mem_ok);
				default:              dcond = dir_ok;
			endcase
		end

		assign cond[s]     = oc & dcond & ~block_in[s];
		assign trip_hit[s] = cond[s] & (acc_ff[s] >= limit);

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				acc_ff[s] <= 32'h00000000;
			else if (~cond[s])
				acc_ff[s] <= 32'h00000000;
			else if (tick & ~trip_hit[s])
				acc_ff[s] <= acc_ff[s] + 32'(dep ? i_max : thr);
		end
	end

	// ======================================================================
	// Outputs and events
	wire [7:0]   evt_set = {trip_hit & ~trip_ff, cond & ~start_ff}
	                     & {8{evt_en_ff}};
	wire [7:0]   clr     = (wr_en & hit_iclr) ? pwdata[7:0] : 8'h00;
	wire [7:0]   nxt_ist = evt_set | (irq_stat_ff & ~clr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_ff    <= 4'h0;
			trip_ff     <= 4'h0;
			irq_stat_ff <= 8'h00;
			irq_ff      <= 1'b0;
		end
		else
		begin
			start_ff    <= cond;
			trip_ff     <= trip_hit;
			irq_stat_ff <= nxt_ist;
			irq_ff      <= |(nxt_ist & irq_en_ff);
		end
	end

	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign start_out = start_ff;
	assign trip_out  = trip_ff;
	assign irq       = irq_ff;

endmodule : dop_stage_top

// ---- sim/dop_front_model.sv ----
// Measurement front end model: magnitudes and angles on pclk.
// Assumes the bench calls put right after a rising edge or anywhere.
`timescale 1ns/1ns

module dop_front_model (
	// Clock
	input wire logic pclk,
	// Measurements
	output logic [15:0]        i_l1_mag,
	output logic [15:0]        i_l2_mag,
	output logic [15:0]        i_l3_mag,
	output logic [15:0]        u_l12_mag,
	output logic [15:0]        u_l23_mag,
	output logic [15:0]        u_l31_mag,
	output dop_pkg::dop_angle_t pos_seq_cur_ang,
	output dop_pkg::dop_angle_t pos_seq_volt_ang,
	output dop_pkg::dop_angle_t flt_cur_ang,
	output dop_pkg::dop_angle_t healthy_ll_ang,
	output logic               earth_fault
);
	// ======================================================================
	// Drive a new measurement set at a rising edge
	task automatic put(input logic [15:0] i, input dop_pkg::dop_angle_t pc,
		input dop_pkg::dop_angle_t pv, input dop_pkg::dop_angle_t fc,
		input logic ef, input logic [15:0] u);
		@(posedge pclk);
		i_l1_mag         <= i >> 1;
		i_l2_mag         <= i;
		i_l3_mag         <= i >> 2;
		u_l12_mag        <= u;
		u_l23_mag        <= u;
		u_l31_mag        <= u;
		pos_seq_cur_ang  <= pc;
		pos_seq_volt_ang <= pv;
		flt_cur_ang      <= fc;
		healthy_ll_ang   <= pv;
		earth_fault      <= ef;
	endtask : put

	initial
	begin
		{i_l1_mag, i_l2_mag, i_l3_mag} = 48'h000000000000;
		{u_l12_mag, u_l23_mag, u_l31_mag} = 48'h400040004000;
		{pos_seq_cur_ang, pos_seq_volt_ang} = 18'h00000;
		{flt_cur_ang, healthy_ll_ang} = 18'h00000;
		earth_fault = 1'b0;
	end
endmodule : dop_front_model

// ---- sim/dop_stage_asserts.sv ----
// Port-level checker for the directional overcurrent block.
// Assumes binding to dop_stage_top; one clock, reset low.
`timescale 1ns/1ns

module dop_stage_asserts (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Protection
	input wire logic [15:0] i_l1_mag,
	input wire logic [15:0] i_l2_mag,
	input wire logic [15:0] i_l3_mag,
	input wire logic [3:0]  block_in,
	input wire logic [3:0]  start_out,
	input wire logic [3:0]  trip_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ======================================================================
	// Bus handshake
	sequence s_access;
		psel && penable && !pready;
	endsequence

	a_access_ready: assert property (s_access |=> pready)
		else $error("no pready after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
		else $error("prdata not zero outside answer");

	// ======================================================================
	// Protection outputs
	a_block_clears: assert property (
		1'b1 |=> ((start_out | trip_out) & $past(block_in)) == 4'h0)
		else $error("blocked stage still active");
	a_trip_with_start: assert property (
		(trip_out & ~start_out) == 4'h0)
		else $error("trip without start");
	a_start_current: assert property (
		start_out != 4'h0 |-> $past(i_l1_mag | i_l2_mag | i_l3_mag) != 16'h0)
		else $error("start without current");
endmodule : dop_stage_asserts

bind dop_stage_top dop_stage_asserts u_dop_stage_asserts (.pclk, .presetn,
	.psel, .penable, .prdata, .pready, .pslverr, .i_l1_mag, .i_l2_mag,
	.i_l3_mag, .block_in, .start_out, .trip_out);

// ---- sim/testbench.sv ----
// Self-checking bench for the directional overcurrent block.
// Assumes a 1 ms tick of 10 clocks and the front end model.
`timescale 1ns/1ns
`include "dop_regs.svh"

module testbench;
	logic                pclk;
	logic                presetn = 1'b0;
	logic                psel    = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite  = 1'b0;
	logic [11:0]         paddr   = 12'h000;
	logic [31:0]         pwdata  = 32'h00000000;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                irq;
	logic [3:0]          block_in = 4'h0;
	logic [3:0]          start_out;
	logic [3:0]          trip_out;
	logic [15:0]         i_l1_mag, i_l2_mag, i_l3_mag;
	logic [15:0]         u_l12_mag, u_l23_mag, u_l31_mag;
	dop_pkg::dop_angle_t pos_seq_cur_ang, pos_seq_volt_ang;
	dop_pkg::dop_angle_t flt_cur_ang, healthy_ll_ang;
	logic                earth_fault;
	int                  n_fail   = 0;
	int                  n_checks = 0;

	dop_stage_top #(.TICK_CYC(10), .VNOM(16'h4000)) u_dop_stage_top (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .i_l1_mag, .i_l2_mag, .i_l3_mag, .u_l12_mag,
		.u_l23_mag, .u_l31_mag, .pos_seq_cur_ang, .pos_seq_volt_ang,
		.flt_cur_ang, .healthy_ll_ang, .earth_fault, .block_in,
		.start_out, .trip_out, .irq);
	dop_front_model u_dop_front_model (.pclk, .i_l1_mag, .i_l2_mag,
		.i_l3_mag, .u_l12_mag, .u_l23_mag, .u_l31_mag, .pos_seq_cur_ang,
		.pos_seq_volt_ang, .flt_cur_ang, .healthy_ll_ang, .earth_fault);

	// ======================================================================
	// Shared tasks
	task automatic finish_test;
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_checks++;
		if (g !== x)
		begin
			$display("ERROR %s exp %h got %h", nm, x, g);
			n_fail++;
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk($sformatf("reg %h", a), x, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask : rd

	task automatic outs(input logic [3:0] s, input logic [3:0] t);
		chk("start_out", {28'h0, s}, {28'h0, start_out});
		chk("trip_out", {28'h0, t}, {28'h0, trip_out});
	endtask : outs

	task automatic fe(input logic [15:0] i, input dop_pkg::dop_angle_t pc,
		input dop_pkg::dop_angle_t pv, input dop_pkg::dop_angle_t fc,
		input logic ef, input logic [15:0] u);
		u_dop_front_model.put(i, pc, pv, fc, ef, u);
	endtask : fe

	// ======================================================================
	// Scenarios
	task automatic t_regs;
		rd(`DOP_CTRL_OFF, 32'h00000A00, 1'b0);
		rd(`DOP_SET_BASE, 32'h0000FFFF, 1'b0);
		rd(12'h104, 32'h00000064, 1'b0);
		rd(12'h020, 32'h00000000, 1'b1);
		wr(`DOP_CTRL_OFF, 32'h00000110);
		rd(`DOP_CTRL_OFF, 32'h00000210, 1'b0);
		wr(`DOP_SET_BASE, 32'h00000100);
		wr(12'h104, 32'h00000002);
		wr(`DOP_IRQ_EN_OFF, 32'h00000011);
	endtask : t_regs

	task automatic t_dir;
		int n;
		fe(16'h0100, 9'sd0, 9'sd0, 9'sd0, 1'b0, 16'h4000);
		cyc(2);
		outs(4'h0, 4'h0);
		fe(16'h0101, 9'sd89, 9'sd0, 9'sd0, 1'b0, 16'h4000);
		cyc(2);
		outs(4'h0, 4'h0);
		fe(16'h0101, 9'sd88, 9'sd0, 9'sd0, 1'b0, 16'h4000);
		cyc(1);
		outs(4'h1, 4'h0);
		cyc(8);
		outs(4'h1, 4'h0);
		n = 0;
		while (trip_out[0] !== 1'b1 && n < 30)
		begin
			cyc(1);
			n++;
		end
		outs(4'h1, 4'h1);
		chk("irq", 32'h00000001, {31'h0, irq});
		rd(`DOP_IRQ_STAT_OFF, 32'h00000011, 1'b0);
		wr(`DOP_IRQ_CLR_OFF, 32'h00000011);
		cyc(1);
		chk("irq", 32'h00000000, {31'h0, irq});
		rd(`DOP_IRQ_STAT_OFF, 32'h00000000, 1'b0);
		fe(16'h0101, -9'sd88, 9'sd0, 9'sd0, 1'b0, 16'h4000);
		cyc(2);
		chk("start_out", 32'h00000001, {28'h0, start_out});
	endtask : t_dir

	task automatic t_block;
		@(posedge pclk);
		block_in <= 4'h1;
		cyc(1);
		outs(4'h0, 4'h0);
		@(posedge pclk);
		block_in <= 4'h0;
		cyc(1);
		outs(4'h1, 4'h0);
	endtask : t_block

	task automatic t_earth;
		fe(16'h0101, -9'sd180, 9'sd0, -9'sd90, 1'b1, 16'h4000);
		cyc(2);
		outs(4'h1, 4'h0);
		fe(16'h0101, 9'sd88, 9'sd0, 9'sd0, 1'b1, 16'h4000);
		cyc(2);
		outs(4'h0, 4'h0);
		fe(16'h0101, -9'sd180, 9'sd0, -9'sd2, 1'b1, 16'h4000);
		cyc(2);
		outs(4'h1, 4'h0);
	endtask : t_earth

	task automatic t_nondir;
		wr(12'h10C, 32'h00000001);
		fe(16'h0101, -9'sd180, 9'sd0, 9'sd90, 1'b0, 16'h4000);
		cyc(2);
		outs(4'h1, 4'h0);
		fe(16'h0100, -9'sd180, 9'sd0, 9'sd90, 1'b0, 16'h4000);
		cyc(2);
		outs(4'h0, 4'h0);
	endtask : t_nondir

	// Stages 1 and 2, group 1: non-directional, dependent bit set
	task automatic t_groups;
		wr(12'h150, 32'h00000080);
		wr(12'h154, 32'h00000004);
		wr(12'h15C, 32'h00000005);
		wr(12'h190, 32'h00000080);
		wr(12'h194, 32'h00000004);
		wr(12'h19C, 32'h00000005);
		rd(12'h15C, 32'h00000005, 1'b0);
		wr(`DOP_CTRL_OFF, 32'h00000111);
		cyc(1);
		outs(4'h6, 4'h0);
		cyc(20);
		outs(4'h6, 4'h2);
		cyc(20);
		outs(4'h6, 4'h6);
		wr(`DOP_CTRL_OFF, 32'h00000110);
		cyc(2);
		outs(4'h0, 4'h0);
	endtask : t_groups

	task automatic t_memory;
		wr(12'h10C, 32'h00000000);
		fe(16'h0010, 9'sd0, 9'sd0, 9'sd0, 1'b0, 16'h4000);
		cyc(3100);
		fe(16'h0101, 9'sd0, -9'sd180, 9'sd0, 1'b0, 16'h0000);
		cyc(3);
		chk("start_out", 32'h00000001, {28'h0, start_out});
		rd(`DOP_STATUS_OFF, 32'h00000601, 1'b0);
		cyc(3100);
		outs(4'h0, 4'h0);
		rd(`DOP_STATUS_OFF, 32'h00000200, 1'b0);
		wr(12'h10C, 32'h00000002);
		cyc(3);
		chk("start_out", 32'h00000001, {28'h0, start_out});
	endtask : t_memory

	// ======================================================================
	// Clock, reset, sequence and watchdog
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_dir();
		t_block();
		t_earth();
		t_nondir();
		t_groups();
		t_memory();
		finish_test();
	end

	initial
	begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		finish_test();
	end
endmodule : testbench
